// ---- gpios_pad_model.sv ----
/*
  pin-side model: resolves each pad from the port driver, an external
  driver and the pull-up. assumes the port's aclk.
*/
`timescale 1ns/1ps
module gpios_pad_model #(
  parameter int PINS = 8
) (
  input  wire logic            aclk,
  input  wire logic [PINS-1:0] pad_out,
  input  wire logic [PINS-1:0] pad_oe,
  input  wire logic [PINS-1:0] pad_pullup_en,
  input  wire logic [PINS-1:0] ext_val,
  input  wire logic [PINS-1:0] ext_en,
  output logic      [PINS-1:0] pad_in
);
  logic [PINS-1:0] last_q = '0;
  // a floating pad shows a value that flips every cycle
  always_ff @(posedge aclk) last_q <= pad_in;
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pullup_en[i]) pad_in[i] = 1'b1;
      else pad_in[i] = ~last_q[i];
    end
  end
endmodule

// ---- gpios_pkg.sv ----
/*
  constants for the eight-pin general purpose port: register indexes,
  control field positions, sense codes and reset values.
  assumes a 32-bit register bus where byte address = 4 * index.
*/
package gpios_pkg;

  // ----------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] DRIVE_ENABLE_FLIP_IDX       = 6'h03;
  localparam logic [5:0] DRIVE_LEVEL_LATCH_IDX       = 6'h04;
  localparam logic [5:0] DRIVE_LEVEL_SET_ALIAS_IDX   = 6'h05;
  localparam logic [5:0] DRIVE_LEVEL_CLEAR_ALIAS_IDX = 6'h06;
  localparam logic [5:0] DRIVE_LEVEL_FLIP_ALIAS_IDX  = 6'h07;
  localparam logic [5:0] SAMPLED_LEVEL_IDX           = 6'h08;
  localparam logic [5:0] PIN_EVENT_FLAG_REG_IDX      = 6'h09;
  localparam logic [5:0] PAD_CONTROL_IDX             = 6'h10;

  // ----------------------------------------------------------------
  // pad_control fields
  // ----------------------------------------------------------------
  localparam int POLARITY_FLIP_ENABLE_POS       = 7;
  localparam int WEAK_HIGH_RESISTOR_ENABLE_POS  = 3;
  localparam int SENSE_SELECT_LSB               = 0;
  localparam int SENSE_SELECT_W                 = 3;

  // ----------------------------------------------------------------
  // sense codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SENSE_OFF_BUFFER_ON = 3'h0;
  localparam logic [2:0] SENSE_ANY_EDGE      = 3'h1;
  localparam logic [2:0] SENSE_RISING        = 3'h2;
  localparam logic [2:0] SENSE_FALLING       = 3'h3;
  localparam logic [2:0] SENSE_BUFFER_OFF    = 3'h4;
  localparam logic [2:0] SENSE_LOW_LEVEL     = 3'h5;

  // ----------------------------------------------------------------
  // reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_REG_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

endpackage

// ---- gpios_port.sv ----
/*
  eight-pin general purpose port with axi4-lite register access:
  driver enable, drive level latch with set/clear/flip aliases,
  synchronised input sampling, per-pin event flags and pad control.
  assumes pins are asynchronous to aclk and the pad cell combines
  drive, enable and pull-up itself.
// Operation
// RULE1: writing one to drive_enable_flip bit inverts that driver enable
// RULE2: reading drive_enable_flip returns the driver enable register
// RULE3: zero bits written to any alias leave targets untouched
// RULE4: latch bit drives pad low or high only while driver enabled
// RULE5: one written to set alias forces latch bit high
// RULE6: one written to clear alias forces latch bit low
// RULE7: one written to flip alias or sampled level inverts latch bit
// RULE8: set, clear and flip aliases read back the latch
// RULE9: sampled level reports pin level while input buffer is on
// RULE10: buffer off holds sampled level bit, stops sampling
// RULE11: event flag sets when pin matches its sense selection
// RULE12: writing one clears event flag, zero leaves it
// RULE13: polarity flip enable inverts both input and output
// RULE14: pull-up enabled when its bit set and pin input-only
// RULE15: sense codes 1,2,3 pick both, rising, falling edges
// RULE16: code 0 buffer on no sense, 4 all off, 5 low level
// RULE17: driver enable zero means input-only, one means output
// RULE18: all registers and sampling run on the port clock
// RULE19: pin inputs synchronised before detection and sampling
// RULE20: reserved sense codes act as code 0, reserved bits read zero
*/
`timescale 1ns/1ps

module gpios_port #(
  parameter int PINS   = 8,
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [PINS-1:0]   pad_in,
  output logic [PINS-1:0]        pad_out,
  output logic [PINS-1:0]        pad_oe,
  output logic [PINS-1:0]        pad_pullup_en
);

  // ----------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [5:0] idx);
    is_mapped = (idx >= gpios_pkg::DRIVE_ENABLE_FLIP_IDX &&
                 idx <= gpios_pkg::PIN_EVENT_FLAG_REG_IDX) ||
                (idx >= gpios_pkg::PAD_CONTROL_IDX &&
                 idx <  gpios_pkg::PAD_CONTROL_IDX + 6'(PINS));
  endfunction

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [PINS-1:0] dir_q;
  logic [PINS-1:0] dir_d;
  logic [PINS-1:0] lvl_q;
  logic [PINS-1:0] lvl_d;
  logic [PINS-1:0] in_q;
  logic [PINS-1:0] flag_q;
  logic [PINS-1:0] inv_q;
  logic [PINS-1:0] pu_q;
  logic [2:0]      isc_q [PINS];

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic              aw_full_q;
  logic              aw_full_d;
  logic [5:0]        aw_idx_q;
  logic              w_full_q;
  logic              w_full_d;
  logic [7:0]        w_byte_q;
  logic              w_lane0_q;
  logic              bvalid_d;
  logic              awready_d;
  logic              wready_d;
  logic              wr_go;
  logic              wr_en;
  logic [7:0]        wr_data;

  assign wr_go   = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign wr_en   = wr_go & w_lane0_q & is_mapped(aw_idx_q);
  assign wr_data = w_byte_q;

  assign aw_full_d = wr_go ? 1'b0
                   : aw_full_q | (s_axi_awvalid & s_axi_awready);
  assign w_full_d  = wr_go ? 1'b0
                   : w_full_q | (s_axi_wvalid & s_axi_wready);
  assign bvalid_d  = wr_go | (s_axi_bvalid & ~s_axi_bready);
  assign awready_d = ~aw_full_d & ~bvalid_d;
  assign wready_d  = ~w_full_d & ~bvalid_d;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      aw_idx_q      <= 6'h00;
      w_byte_q      <= 8'h00;
      w_lane0_q     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= gpios_pkg::RESP_OKAY;
    end else begin
      aw_full_q     <= aw_full_d;
      w_full_q      <= w_full_d;
      s_axi_awready <= awready_d;
      s_axi_wready  <= wready_d;
      s_axi_bvalid  <= bvalid_d;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_idx_q <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_byte_q  <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        s_axi_bresp <= is_mapped(aw_idx_q) ? gpios_pkg::RESP_OKAY
                                           : gpios_pkg::RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  wire wr_dir_flip = wr_en && aw_idx_q == gpios_pkg::DRIVE_ENABLE_FLIP_IDX;
  wire wr_latch = wr_en && aw_idx_q == gpios_pkg::DRIVE_LEVEL_LATCH_IDX;
  wire wr_set = wr_en && aw_idx_q == gpios_pkg::DRIVE_LEVEL_SET_ALIAS_IDX;
  wire wr_clr = wr_en && aw_idx_q == gpios_pkg::DRIVE_LEVEL_CLEAR_ALIAS_IDX;
  wire wr_flip = wr_en &&
                 (aw_idx_q == gpios_pkg::DRIVE_LEVEL_FLIP_ALIAS_IDX ||
                  aw_idx_q == gpios_pkg::SAMPLED_LEVEL_IDX);
  wire wr_flag = wr_en && aw_idx_q == gpios_pkg::PIN_EVENT_FLAG_REG_IDX;

  wire [PINS-1:0] wr_mask = wr_data[PINS-1:0];

  // zero bits of an alias write leave the target alone  // see RULE3
  assign dir_d = wr_dir_flip ? dir_q ^ wr_mask : dir_q;  // see RULE1

  always_comb begin
    lvl_d = lvl_q;
    if (wr_latch) begin
      lvl_d = wr_mask;
    end
    if (wr_set) begin
      lvl_d = lvl_q | wr_mask;  // see RULE5
    end
    if (wr_clr) begin
      lvl_d = lvl_q & ~wr_mask;  // see RULE6
    end
    if (wr_flip) begin
      lvl_d = lvl_q ^ wr_mask;  // see RULE7
    end
  end

  // all state runs on aclk; no clock, no sampling  // see RULE18
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q <= gpios_pkg::PORT_REG_RESET[PINS-1:0];
      lvl_q <= gpios_pkg::PORT_REG_RESET[PINS-1:0];
    end else begin
      dir_q <= dir_d;
      lvl_q <= lvl_d;
    end
  end

  // ----------------------------------------------------------------
  // per-pin input path, sense and control
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic settled_q;
      logic prev_q;
      logic buf_on;
      logic lvl_now;
      logic rise;
      logic fall;
      logic hit;
      logic wr_ctrl;

      assign wr_ctrl = wr_en &&
                       aw_idx_q == gpios_pkg::PAD_CONTROL_IDX + 6'(gi);
      assign buf_on  = isc_q[gi] != gpios_pkg::SENSE_BUFFER_OFF;  // see RULE16
      assign lvl_now = settled_q ^ inv_q[gi];  // see RULE13
      assign rise    = buf_on & lvl_now & ~prev_q;
      assign fall    = buf_on & ~lvl_now & prev_q;

      // reserved codes fall to the default: no sensing  // see RULE20
      always_comb begin
        case (isc_q[gi])
          gpios_pkg::SENSE_ANY_EDGE:  hit = rise | fall;  // see RULE15
          gpios_pkg::SENSE_RISING:    hit = rise;
          gpios_pkg::SENSE_FALLING:   hit = fall;
          gpios_pkg::SENSE_LOW_LEVEL: hit = ~lvl_now;  // see RULE16
          default:                    hit = 1'b0;
        endcase
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1_q        <= 1'b0;
          s2_q        <= 1'b0;
          s3_q        <= 1'b0;
          settled_q   <= 1'b0;
          prev_q      <= 1'b0;
          in_q[gi]    <= 1'b0;
          flag_q[gi]  <= 1'b0;
          inv_q[gi]   <= 1'b0;
          pu_q[gi]    <= 1'b0;
          isc_q[gi]   <= gpios_pkg::SENSE_OFF_BUFFER_ON;
        end else begin
          // three-stage synchroniser, change taken when 2 and 3 agree
          s1_q <= pad_in[gi];  // see RULE19
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            settled_q <= s3_q;
          end
          // buffer off: sampled bit and edge history hold  // see RULE10
          if (buf_on) begin
            prev_q   <= lvl_now;
            in_q[gi] <= lvl_now;  // see RULE9
          end
          // a new hit wins over a clear in the same cycle  // see RULE12
          flag_q[gi] <= (flag_q[gi] & ~(wr_flag & wr_mask[gi]))
                        | hit;  // see RULE11
          if (wr_ctrl) begin
            inv_q[gi] <= wr_data[gpios_pkg::POLARITY_FLIP_ENABLE_POS];
            pu_q[gi]  <= wr_data[gpios_pkg::WEAK_HIGH_RESISTOR_ENABLE_POS];
            isc_q[gi] <= wr_data[gpios_pkg::SENSE_SELECT_LSB +:
                                 gpios_pkg::SENSE_SELECT_W];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // pad outputs
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_out       <= '0;
      pad_oe        <= '0;
      pad_pullup_en <= '0;
    end else begin
      pad_oe        <= dir_q;  // see RULE17
      pad_out       <= (lvl_q ^ inv_q) & dir_q;  // see RULE4
      pad_pullup_en <= pu_q & ~dir_q;  // see RULE14
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  logic [5:0]  rd_idx;
  logic [7:0]  rd_val;
  logic [7:0]  ctrl_rd;
  logic        ar_hs;
  logic        rvalid_d;
  logic [2:0]  ctrl_sel;

  assign rd_idx   = s_axi_araddr[7:2];
  assign ar_hs    = s_axi_arvalid & s_axi_arready;
  assign rvalid_d = ar_hs | (s_axi_rvalid & ~s_axi_rready);
  assign ctrl_sel = rd_idx[2:0];
  // reserved control bits read zero  // see RULE20
  assign ctrl_rd  = {inv_q[ctrl_sel], 3'h0, pu_q[ctrl_sel],
                     isc_q[ctrl_sel]};

  always_comb begin
    rd_val = 8'h00;
    case (rd_idx)
      gpios_pkg::DRIVE_ENABLE_FLIP_IDX:       rd_val = dir_q;  // see RULE2
      gpios_pkg::DRIVE_LEVEL_LATCH_IDX,
      gpios_pkg::DRIVE_LEVEL_SET_ALIAS_IDX,
      gpios_pkg::DRIVE_LEVEL_CLEAR_ALIAS_IDX,
      gpios_pkg::DRIVE_LEVEL_FLIP_ALIAS_IDX:  rd_val = lvl_q;  // see RULE8
      gpios_pkg::SAMPLED_LEVEL_IDX:           rd_val = in_q;
      gpios_pkg::PIN_EVENT_FLAG_REG_IDX:      rd_val = flag_q;
      default: begin
        if (is_mapped(rd_idx)) begin
          rd_val = ctrl_rd;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= gpios_pkg::RESP_OKAY;
    end else begin
      s_axi_rvalid  <= rvalid_d;
      s_axi_arready <= ~rvalid_d;
      if (ar_hs) begin
        s_axi_rdata <= {24'h00_0000, rd_val};
        s_axi_rresp <= is_mapped(rd_idx) ? gpios_pkg::RESP_OKAY
                                         : gpios_pkg::RESP_SLVERR;
      end
    end
  end

endmodule

// ---- gpios_port_props.sv ----
/*
  bus and pad assertions for gpios_port.
  assumes binding onto gpios_port, one clock domain.
*/
`timescale 1ns/1ps
module gpios_port_props #(
  parameter int PINS = 8
) (
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire logic            s_axi_awvalid,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wvalid,
  input wire logic            s_axi_wready,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic [1:0]      s_axi_bresp,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input wire logic [31:0]     s_axi_rdata,
  input wire logic [PINS-1:0] pad_out,
  input wire logic [PINS-1:0] pad_oe,
  input wire logic [PINS-1:0] pad_pullup_en
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  chk_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer missing");
  chk_busy_refuse: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("ready during answer");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  chk_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("rdata high");
  chk_out_gated: assert property (
    (pad_out & ~pad_oe) == '0) else $error("pad driven while off");
  chk_pullup_input: assert property (
    (pad_pullup_en & pad_oe) == '0) else $error("pull-up on output");
  chk_reset_quiet: assert property ($rose(aresetn) |->
    pad_oe == '0 && !s_axi_awready) else $error("outputs after reset");
endmodule

bind gpios_port gpios_port_props #(.PINS(PINS)) u_props (.*);

// ---- tb_top.sv ----
/*
  self-checking bench for gpios_port with a pad model.
  assumes the axi4-lite timing of the port and 5 ns aclk.
*/
`timescale 1ns/1ps
module tb_top;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, pad_in, pad_out, pad_oe;
  logic [7:0]  pad_pullup_en, ext_val, ext_en;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  int          failures, n_compared, cyc;
  logic [7:0]  t_wa [10] = '{8'h0c, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
                             8'h20, 8'h48, 8'h48, 8'h2c};
  logic [7:0]  t_wd [10] = '{8'ha5, 8'h0f, 8'h3c, 8'h81, 8'h0c, 8'hff,
                             8'h0f, 8'h8b, 8'h7e, 8'hff};
  logic [7:0]  t_ra [10] = '{8'h0c, 8'h0c, 8'h10, 8'h18, 8'h1c, 8'h14,
                             8'h10, 8'h48, 8'h48, 8'h2c};
  logic [7:0]  t_rv [10] = '{8'ha5, 8'haa, 8'h3c, 8'hbd, 8'hb1, 8'h4e,
                             8'h41, 8'h8b, 8'h0e, 8'h00};
  logic [1:0]  t_rs [10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
                             2'h0, 2'h0, 2'h2};
  logic [7:0]  fall_m = 8'h2a;
  logic [7:0]  rise_m = 8'h26;

  gpios_port uut (.*);
  gpios_pad_model u_pads (.aclk(aclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup_en(pad_pullup_en), .ext_val(ext_val), .ext_en(ext_en),
    .pad_in(pad_in));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic close_out();
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  task automatic cmp_v(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_r(input logic [1:0] got, input logic [1:0] exp);
    cmp_v({30'h0, got}, {30'h0, exp});
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'h1;
    ext_val = 8'h00;
    ext_en = 8'hff;
    tick(20);
    aresetn <= 1'b1;
    tick(2);
    for (int a = 12; a <= 92; a += 4) begin
      if (a <= 36 || a >= 64) begin
        rdr(8'(a));
        cmp_v(rd, 32'h0);
      end
    end
    for (int i = 0; i < 10; i++) begin
      wr(t_wa[i], {24'h0, t_wd[i]});
      cmp_r(rsp, t_rs[i]);
      rdr(t_ra[i]);
      cmp_v(rd, {24'h0, t_rv[i]});
      cmp_r(rsp, t_rs[i]);
    end
    s_axi_wstrb <= 4'h0;
    wr(8'h10, 32'hff);
    cmp_r(rsp, 2'h0);
    s_axi_wstrb <= 4'h1;
    rdr(8'h10);
    cmp_v(rd, 32'h41);
    wr(8'h10, 32'h5a);
    tick(2);
    cmp_v(32'(pad_out), 32'h0a);
    cmp_v(32'(pad_oe), 32'haa);
    cmp_v(32'(pad_pullup_en), 32'h04);
    wr(8'h44, 32'h80);
    tick(2);
    cmp_v(32'(pad_out), 32'h08);
    ext_val <= 8'h55;
    ext_en <= 8'h55;
    tick(8);
    rdr(8'h20);
    cmp_v(rd, 32'h5f);
    for (int c = 0; c < 8; c++) begin
      wr(8'h40, 32'(c));
      ext_val[0] <= 1'b1;
      tick(8);
      wr(8'h24, 32'hff);
      ext_val[0] <= 1'b0;
      tick(8);
      rdr(8'h24);
      cmp_v(rd, {31'h0, fall_m[c]});
      wr(8'h24, 32'hff);
      ext_val[0] <= 1'b1;
      tick(8);
      rdr(8'h24);
      cmp_v(rd, {31'h0, rise_m[c]});
    end
    wr(8'h40, 32'h1);
    ext_val[0] <= 1'b0;
    tick(8);
    wr(8'h24, 32'hfe);
    rdr(8'h24);
    cmp_v(rd, 32'h1);
    wr(8'h40, 32'h4);
    ext_val[0] <= 1'b1;
    tick(8);
    rdr(8'h20);
    cmp_v(rd & 32'h1, 32'h0);
    wr(8'h24, 32'h01);
    rdr(8'h24);
    cmp_v(rd, 32'h0);
    wr(8'h40, 32'h0);
    tick(8);
    rdr(8'h20);
    cmp_v(rd & 32'h1, 32'h1);
    aresetn <= 1'b0;
    tick(2);
    aresetn <= 1'b1;
    tick(2);
    rdr(8'h10);
    cmp_v(rd, 32'h0);
    cmp_v(32'(pad_oe), 32'h0);
    close_out();
  end
endmodule
